// file: common/spims_map.vh
// Register offsets, control bit positions, reset values for the SPI port.
// Assumes APB with 32-bit data, one aligned word per register.
`ifndef SPIMS_MAP_VH
`define SPIMS_MAP_VH
`define SPIMS_ADDR_W 5
`define SPIMS_OFF_CTRL 5'h00
`define SPIMS_OFF_STAT 5'h04
`define SPIMS_OFF_DIV 5'h08
`define SPIMS_OFF_TX 5'h0C
`define SPIMS_OFF_RX 5'h10
`define SPIMS_CTRL_W 13
`define SPIMS_CTRL_RST 13'h0000
`define SPIMS_DIV_RST 8'h00
`define SPIMS_B_EN 0
`define SPIMS_B_MST 1
`define SPIMS_B_CPHA 2
`define SPIMS_B_CPOL 3
`define SPIMS_B_LSB 5
`define SPIMS_B_TIMOD 6
`define SPIMS_B_ZERO 7
`define SPIMS_B_ROW 8
`define SPIMS_B_SSEN 9
`define SPIMS_B_SOEN 10
`define SPIMS_B_LOOP 11
`define SPIMS_B_CONT 12
`define SPIMS_CTRL_MASK 13'h1FEF
`define SPIMS_BITS 4'h8
`define SPIMS_STALL 8'h02
`endif

// file: hdl/spims_shift.v
// Eight-bit shift engine: loads a byte, shifts out and in, MSB or LSB first.
// Assumes the caller gives one launch and one sample strobe per bit, in order.
`timescale 1ns/1ps
module spims_shift #(
  parameter W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire load,
  input wire [W-1:0] load_data,
  input wire lsb_first,
  input wire sample,
  input wire shift,
  input wire din,
  output wire dout,
  output wire [W-1:0] rx_data
);
  reg [W-1:0] sreg;
  reg in_bit;
  assign dout = lsb_first ? sreg[0] : sreg[W-1];
  assign rx_data = sreg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sreg <= {W{1'b0}};
      in_bit <= 1'b0;
    end else if (ce) begin
      if (load) begin
        sreg <= load_data;
      end else begin
        if (sample) begin
          in_bit <= din;
        end
        if (shift) begin
          if (lsb_first) begin
            sreg <= {(sample ? din : in_bit), sreg[W-1:1]};
          end else begin
            sreg <= {sreg[W-2:0], (sample ? din : in_bit)};
          end
        end
      end
    end
  end
endmodule // spims_shift

// file: hdl/spims_top.v
// SPI master/slave port with APB register access, 8-bit characters.
// Assumes pins are synchronised here; slave clock well below pclk/4.
// Function
// - Slave transfer framed by low select input
// - Continuous mode keeps select low until empty, with interrupt-mode bit set
// - Single mode stalls between successive bytes
// - Loopback feeds transmit data back to receive
// - Slave data output driven only when enabled
// - Select output enabled by control bit, master
// - Overwrite bit chooses replace or discard on overflow
// - Underflow resends last byte or zeros
// - Transfer start and interrupt source by mode
// - Bit order selectable, LSB or MSB first
// - Clock polarity sets idle level
// - Phase chooses pulse at start or end
// - Master or slave role by control bit
// - Port works only while enable set
// - Receive overflow flag, cleared by read
// - Receive interrupt flag follows full or overflow
// - Receive full flag, cleared by read
// - Transmit underflow flag, cleared by write
// - Transmit interrupt flag follows empty or underflow
// - Transmit empty flag, cleared by write
// - Data and status registers eight bits
// - Bit clock is pclk over 2(1+div)
// - Launch on one edge, sample on other
`timescale 1ns/1ps
`include "spims_map.vh"
module spims_top (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SPIMS_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sclk_in,
  output reg sclk_out,
  output reg sclk_oe,
  input wire mosi_in,
  output reg mosi_out,
  output reg mosi_oe,
  input wire miso_in,
  output reg miso_out,
  output reg miso_oe,
  input wire slave_select_n,
  output reg slave_select_out_n,
  output reg slave_select_oe,
  output reg irq
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_RUN = 4'b0010;
  localparam ST_STALL = 4'b0100;
  localparam ST_SLV = 4'b1000;
  reg [`SPIMS_CTRL_W-1:0] ctrl;
  reg [7:0] div;
  reg [7:0] tx_hold;
  reg [7:0] tx_last;
  reg tx_full;
  reg [7:0] rx_hold;
  reg rx_full;
  reg rx_ovf;
  reg tx_unf;
  reg [3:0] state;
  reg [7:0] div_cnt;
  reg half;
  reg [3:0] bit_cnt;
  reg [7:0] stall_cnt;
  reg start_req;
  reg [2:0] sclk_s;
  reg [1:0] ssn_s;
  reg [1:0] mosi_s;
  reg [1:0] miso_s;
  wire en = ctrl[`SPIMS_B_EN];
  wire mst = ctrl[`SPIMS_B_MST];
  wire cpha = ctrl[`SPIMS_B_CPHA];
  wire cpol = ctrl[`SPIMS_B_CPOL];
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire wr_tx = wr & (paddr == `SPIMS_OFF_TX);
  wire rd_rx = rd & (paddr == `SPIMS_OFF_RX);
  wire mapped = (paddr == `SPIMS_OFF_CTRL) | (paddr == `SPIMS_OFF_STAT) |
    (paddr == `SPIMS_OFF_DIV) | (paddr == `SPIMS_OFF_TX) | (paddr == `SPIMS_OFF_RX);
  wire [7:0] status;
  wire [7:0] shift_rx;
  wire shift_dout;
  // Master: half period = div+1 pclk cycles, so full period 2(1+div)
  wire tick = (state == ST_RUN) & (div_cnt == div);
  // First half edge is leading, second is trailing within each bit
  wire m_lead = tick & ~half;
  wire m_trail = tick & half;
  // Slave: edges of synchronised clock, relative to idle polarity
  wire s_rise = sclk_s[1] & ~sclk_s[2];
  wire s_fall = ~sclk_s[1] & sclk_s[2];
  wire s_lead = cpol ? s_fall : s_rise;
  wire s_trail = cpol ? s_rise : s_fall;
  wire lead = mst ? m_lead : s_lead;
  wire trail = mst ? m_trail : s_trail;
  // CPHA=0 samples leading, launches trailing; CPHA=1 the reverse
  wire smp = (state == ST_RUN | state == ST_SLV) & (cpha ? trail : lead);
  wire lnc = (state == ST_RUN | state == ST_SLV) & (cpha ? lead : trail);
  // No launch before the first sample; also keeps a slave reload from being shifted
  wire first_lnc = (bit_cnt == 4'h0);
  wire last_smp = smp & (bit_cnt == `SPIMS_BITS - 4'h1);
  // Eighth trailing edge ends the byte; with CPHA=1 it is also the eighth sample
  wire m_end = m_trail & (bit_cnt == (cpha ? `SPIMS_BITS - 4'h1 : `SPIMS_BITS));
  wire din_raw = mst ? miso_s[1] : mosi_s[1];
  wire din = ctrl[`SPIMS_B_LOOP] ? shift_dout : din_raw;
  wire [7:0] next_tx_byte = tx_full ? tx_hold : (ctrl[`SPIMS_B_ZERO] ? tx_last : 8'h00);
  wire slave_active = en & ~mst & ~ssn_s[1];
  wire go_s = slave_active;
  // Interrupt-mode bit selects which event kicks a master transfer
  wire go_m = en & mst & (ctrl[`SPIMS_B_TIMOD] ? tx_full : start_req);
  wire load = (state == ST_IDLE) & (go_m | go_s);
  wire byte_done = last_smp;
  spims_shift #(.W(8)) u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .load(load),
    .load_data(next_tx_byte),
    .lsb_first(ctrl[`SPIMS_B_LSB]),
    .sample(smp),
    .shift(lnc & ~first_lnc | last_smp),
    .din(din),
    .dout(shift_dout),
    .rx_data(shift_rx)
  );
  assign status = {2'b00, rx_ovf, (rx_full | rx_ovf), rx_full,
    tx_unf, (~tx_full | tx_unf), ~tx_full};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s <= 3'b000;
      ssn_s <= 2'b11;
      mosi_s <= 2'b00;
      miso_s <= 2'b00;
    end else if (clk_en) begin
      sclk_s <= {sclk_s[1:0], sclk_in};
      ssn_s <= {ssn_s[0], slave_select_n};
      mosi_s <= {mosi_s[0], mosi_in};
      miso_s <= {miso_s[0], miso_in};
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SPIMS_CTRL_RST;
      div <= `SPIMS_DIV_RST;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (wr & pready) begin
        if (paddr == `SPIMS_OFF_CTRL) begin
          ctrl <= pwdata[`SPIMS_CTRL_W-1:0] & `SPIMS_CTRL_MASK;
        end
        if (paddr == `SPIMS_OFF_DIV) begin
          div <= pwdata[7:0];
        end
      end
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `SPIMS_OFF_CTRL: prdata <= {19'h00000, ctrl};
          `SPIMS_OFF_STAT: prdata <= {24'h000000, status};
          `SPIMS_OFF_DIV: prdata <= {24'h000000, div};
          `SPIMS_OFF_RX: prdata <= {24'h000000, rx_hold};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold <= 8'h00;
      tx_last <= 8'h00;
      tx_full <= 1'b0;
      rx_hold <= 8'h00;
      rx_full <= 1'b0;
      rx_ovf <= 1'b0;
      tx_unf <= 1'b0;
      start_req <= 1'b0;
    end else if (clk_en) begin
      if (load) begin
        tx_last <= next_tx_byte;
      end
      // Set wins: a new write during load keeps the new byte
      if (wr_tx & pready) begin
        tx_hold <= pwdata[7:0];
        tx_full <= 1'b1;
      end else if (load) begin
        tx_full <= 1'b0;
      end
      if (load & ~tx_full) begin
        tx_unf <= 1'b1;
      end else if (wr_tx & pready) begin
        tx_unf <= 1'b0;
      end
      if (rd_rx & pready & mst & ~ctrl[`SPIMS_B_TIMOD]) begin
        start_req <= 1'b1;
      end else if (load) begin
        start_req <= 1'b0;
      end
      if (byte_done) begin
        if (~rx_full | ctrl[`SPIMS_B_ROW]) begin
          rx_hold <= shift_rx_final(shift_rx, din);
        end
        rx_full <= 1'b1;
        if (rx_full) begin
          rx_ovf <= 1'b1;
        end
      end else if (rd_rx & pready) begin
        rx_full <= 1'b0;
        rx_ovf <= 1'b0;
      end
    end
  end
  function [7:0] shift_rx_final;
    input [7:0] s;
    input d;
    begin
      shift_rx_final = ctrl[`SPIMS_B_LSB] ? {d, s[7:1]} : {s[6:0], d};
    end
  endfunction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      div_cnt <= 8'h00;
      half <= 1'b0;
      bit_cnt <= 4'h0;
      stall_cnt <= 8'h00;
    end else if (clk_en) begin
      if (~en) begin
        state <= ST_IDLE;
        bit_cnt <= 4'h0;
        half <= 1'b0;
        div_cnt <= 8'h00;
      end else begin
        case (state)
          ST_IDLE: begin
            bit_cnt <= 4'h0;
            half <= 1'b0;
            div_cnt <= 8'h00;
            if (go_m) begin
              state <= ST_RUN;
            end else if (go_s) begin
              state <= ST_SLV;
            end
          end
          ST_RUN: begin
            div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
            if (tick) begin
              half <= ~half;
            end
            if (smp) begin
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (m_end) begin
              if (ctrl[`SPIMS_B_CONT] & tx_full) begin
                state <= ST_IDLE;
              end else begin
                state <= ST_STALL;
                stall_cnt <= 8'h00;
              end
            end
          end
          ST_STALL: begin
            stall_cnt <= stall_cnt + 8'h01;
            if (stall_cnt == `SPIMS_STALL) begin
              state <= ST_IDLE;
            end
          end
          ST_SLV: begin
            if (ssn_s[1]) begin
              state <= ST_IDLE;
            end else if (last_smp) begin
              bit_cnt <= 4'h0;
              state <= ST_IDLE;
            end else if (smp) begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_out <= 1'b0;
      sclk_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      slave_select_out_n <= 1'b1;
      slave_select_oe <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (state == ST_RUN & tick) begin
        sclk_out <= ~sclk_out;
      end else if (state != ST_RUN) begin
        sclk_out <= cpol;
      end
      sclk_oe <= en & mst;
      mosi_out <= shift_dout;
      mosi_oe <= en & mst;
      miso_out <= shift_dout;
      miso_oe <= slave_active & ctrl[`SPIMS_B_SOEN];
      slave_select_oe <= en & mst & ctrl[`SPIMS_B_SSEN];
      slave_select_out_n <= ~(state == ST_RUN | (state == ST_IDLE & go_m));
      irq <= en & (ctrl[`SPIMS_B_TIMOD] ? (~tx_full | tx_unf) : (rx_full | rx_ovf));
    end
  end
endmodule // spims_top

// file: dv/spims_sva.sv
// Checker for the SPI port: APB answer timing, pin enables, status relations.
// Assumes binding to spims_top; mirrors control writes seen on the bus.
`timescale 1ns/1ps
`include "spims_map.vh"
module spims_sva (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SPIMS_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sclk_out,
  input wire sclk_oe,
  input wire mosi_oe,
  input wire miso_oe,
  input wire slave_select_out_n,
  input wire slave_select_oe
);
  reg [15:0] c0, c1, c2;
  // Outputs may lag a control write by a cycle, so judge only settled control
  wire st = (c0 == c1) && (c1 == c2);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0 <= 16'h0000;
      c1 <= 16'h0000;
      c2 <= 16'h0000;
    end else if (clk_en) begin
      if (pready && pwrite && paddr == `SPIMS_OFF_CTRL) c0 <= pwdata[15:0];
      c1 <= c0;
      c2 <= c1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_unmapped: assert property (pready && !pwrite && paddr > `SPIMS_OFF_RX
    |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  chk_stat_zero: assert property (pready && !pwrite && paddr == `SPIMS_OFF_STAT
    |-> prdata[31:6] == 26'h0) else $error("status upper bits not zero");
  chk_stat_irq: assert property (pready && !pwrite && paddr == `SPIMS_OFF_STAT
    |-> prdata[1] == (prdata[0] | prdata[2]) && prdata[4] == (prdata[3] | prdata[5]))
    else $error("status irq bits inconsistent");
  chk_mosi_role: assert property (st |-> mosi_oe == (c0[0] && c0[1])
    && sclk_oe == (c0[0] && c0[1])) else $error("master pin enables wrong");
  chk_ss_enable: assert property (st |-> slave_select_oe == (c0[0] && c0[1] && c0[9]))
    else $error("select enable wrong");
  chk_ss_slave: assert property (st && !(c0[0] && c0[1]) |-> slave_select_out_n)
    else $error("select driven low outside master mode");
  chk_miso_gate: assert property (miso_oe |-> c0[10] || c1[10])
    else $error("slave output driven while disabled");
  chk_sclk_idle: assert property (st && c0[0] && c0[1] && c0[9] && slave_select_out_n
    && $past(slave_select_out_n) |-> sclk_out == c0[3]) else $error("clock idle level wrong");
endmodule // spims_sva
bind spims_top spims_sva u_sva (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_out(sclk_out),
  .sclk_oe(sclk_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .slave_select_out_n(slave_select_out_n), .slave_select_oe(slave_select_oe));

// file: dv/spims_peer.sv
// Behavioural SPI slave at the far side, always MSB first.
// Assumes cpol and cpha are set to match the port; line has no pull.
`timescale 1ns/1ps
module spims_peer (
  input wire sck,
  input wire ss_n,
  input wire mosi,
  input wire cpol,
  input wire cpha,
  input wire [7:0] tx,
  output reg miso,
  output reg [7:0] rx
);
  reg [7:0] sh;
  initial miso = 1'h0;
  initial rx = 8'h00;
  always @(negedge ss_n) begin
    sh = tx;
    if (!cpha) miso = sh[7];
  end
  // Released line must not keep showing the last bit
  always @(posedge ss_n) miso = ~miso;
  always @(sck) begin
    if (!ss_n && (sck ^ cpol ^ cpha)) begin
      rx = {rx[6:0], mosi};
      sh = {sh[6:0], 1'h0};
    end else if (!ss_n) begin
      miso = sh[7];
    end
  end
endmodule // spims_peer

// file: dv/tb.sv
// Self-checking bench for the SPI port in master and slave mode, APB driven.
// Assumes the peer model answers in master mode; the bench itself plays master in slave mode.
`timescale 1ns/1ps
`include "spims_map.vh"
module tb;
  typedef struct packed {logic w; logic [4:0] a; logic [31:0] d; logic [31:0] e; logic x;} spims_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, sd = 0, cpol = 0, cpha = 0;
  logic [4:0] paddr = 5'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [7:0] ptx = 8'h00;
  logic s_sck = 0, s_mosi = 0, s_sel_n = 1;
  logic [7:0] s_got = 8'h00, s_pat = 8'h3C;
  wire s_miso;
  wire [31:0] prdata;
  wire [7:0] prx;
  wire pready, pslverr, sclk_out, mosi_out, ss_n, irq, miso;
  int error_cnt = 0, num_checks = 0, gap = 0, edges = 0, hp = 0, m;
  spims_row_t rows [0:7] = '{'{0, `SPIMS_OFF_CTRL, 0, 0, 0}, '{0, `SPIMS_OFF_DIV, 0, 0, 0},
    '{0, `SPIMS_OFF_STAT, 0, 32'h3, 0}, '{0, 5'h14, 0, 0, 1}, '{1, `SPIMS_OFF_CTRL, 32'hFFFFFFFE, 0, 0},
    '{0, `SPIMS_OFF_CTRL, 0, 32'h1FEE, 0}, '{1, `SPIMS_OFF_DIV, 32'h1FF, 0, 0},
    '{0, `SPIMS_OFF_DIV, 0, 32'hFF, 0}};
  always #4 pclk = ~pclk;
  spims_top uut (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk_in(s_sck), .sclk_out(sclk_out), .sclk_oe(), .mosi_in(s_mosi),
    .mosi_out(mosi_out), .mosi_oe(), .miso_in(miso), .miso_out(s_miso), .miso_oe(),
    .slave_select_n(s_sel_n), .slave_select_out_n(ss_n), .slave_select_oe(), .irq(irq));
  spims_peer u_peer (.sck(sclk_out), .ss_n(ss_n), .mosi(mosi_out), .cpol(cpol), .cpha(cpha),
    .tx(ptx), .miso(miso), .rx(prx));
  always @(posedge pclk) begin
    sd <= sclk_out;
    gap <= gap + 1;
    if (sclk_out !== sd) begin
      gap <= 1;
      hp <= gap;
      if (!ss_n) edges <= edges + 1;
    end
  end
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction
  task results();
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (i == 20) begin
      error_cnt++;
      results();
    end
    @(posedge pclk);
  endtask
  task automatic poll(input int b);
    int i;
    rd = 32'h0;
    for (i = 0; i < 300 && rd[b] !== 1'h1; i++) apb(0, `SPIMS_OFF_STAT, 0);
    if (i == 300) begin
      error_cnt++;
      results();
    end
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].e);
      chk(err, rows[i].x);
    end
    apb(1, `SPIMS_OFF_DIV, 32'h3);
    for (m = 0; m < 4; m++) begin
      cpha <= m[0];
      cpol <= m[1];
      ptx <= 8'hC1 + m;
      apb(1, `SPIMS_OFF_CTRL, 32'h243 | (m << 2) | (m[0] << 5));
      edges <= 0;
      apb(1, `SPIMS_OFF_TX, 32'h30 + m);
      poll(3);
      chk(prx, m[0] ? rev(8'h30 + m) : 8'h30 + m);
      apb(0, `SPIMS_OFF_RX, 0);
      chk(rd, m[0] ? rev(ptx) : ptx);
      chk(edges, 16);
      chk(hp, 4);
      chk(irq, 1);
    end
    cpha <= 1'h0;
    cpol <= 1'h0;
    // Second byte queued during the first: select must stay low over both
    apb(1, `SPIMS_OFF_CTRL, 32'h1243);
    edges <= 0;
    apb(1, `SPIMS_OFF_TX, 32'h11);
    apb(1, `SPIMS_OFF_TX, 32'h22);
    poll(3);
    apb(0, `SPIMS_OFF_RX, 0);
    chk(rd, ptx);
    poll(3);
    chk(prx, 8'h22);
    apb(0, `SPIMS_OFF_RX, 0);
    chk(edges, 32);
    for (m = 0; m < 2; m++) begin
      apb(1, `SPIMS_OFF_CTRL, 32'hA43 | (m << 8));
      apb(1, `SPIMS_OFF_TX, 32'h96);
      poll(3);
      apb(1, `SPIMS_OFF_TX, 32'h69);
      poll(5);
      chk(rd, 32'h3B);
      apb(0, `SPIMS_OFF_RX, 0);
      chk(rd, m ? 32'h69 : 32'h96);
    end
    apb(0, `SPIMS_OFF_STAT, 0);
    chk(rd, 32'h3);
    apb(1, `SPIMS_OFF_CTRL, 32'h203);
    apb(0, `SPIMS_OFF_RX, 0);
    poll(3);
    chk(prx, 0);
    chk(rd[2], 1);
    chk(irq, 1);
    apb(1, `SPIMS_OFF_TX, 32'h5A);
    apb(0, `SPIMS_OFF_STAT, 0);
    chk(rd, 32'h18);
    apb(1, `SPIMS_OFF_CTRL, 32'h283);
    apb(0, `SPIMS_OFF_RX, 0);
    poll(3);
    apb(0, `SPIMS_OFF_RX, 0);
    poll(3);
    chk(prx, 8'h5A);
    apb(1, `SPIMS_OFF_CTRL, 0);
    @(negedge pclk);
    chk(irq, 0);
    @(posedge pclk);
    // Slave mode, CPOL=0 CPHA=0: the bench drives clock, select and data
    apb(0, `SPIMS_OFF_RX, 0);
    apb(1, `SPIMS_OFF_CTRL, 32'h401);
    apb(1, `SPIMS_OFF_TX, 32'hA5);
    s_sel_n <= 1'h0;
    for (m = 7; m >= 0; m--) begin
      s_mosi <= s_pat[m];
      repeat (8) @(posedge pclk);
      s_sck <= 1'h1;
      s_got <= {s_got[6:0], s_miso};
      repeat (8) @(posedge pclk);
      s_sck <= 1'h0;
    end
    repeat (8) @(posedge pclk);
    s_sel_n <= 1'h1;
    repeat (4) @(posedge pclk);
    apb(0, `SPIMS_OFF_RX, 0);
    chk(rd, 32'h3C);
    chk(s_got, 8'hA5);
    results();
  end
endmodule // tb
